// >>> hdl/ldl_fifo.sv
// Small first-in first-out buffer between latch capture and modulator.
// Assumes a single clock; flush empties it in one cycle.
`timescale 1ns/1ps

module ldl_fifo #(
   parameter int W     = 18,
   parameter int DEPTH = 2
) (
   // Clocking
   input  wire logic         clk,
   input  wire logic         rstn,
   input  wire logic         ce,
   input  wire logic         flush,
   // Fill side
   input  wire logic         in_valid,
   input  wire logic [W-1:0] in_data,
   output logic              in_ready,
   // Drain side
   output logic              out_valid,
   output logic [W-1:0]      out_data,
   input  wire logic         out_ready
);

   localparam int AW = $clog2(DEPTH);

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("ldl_fifo depth must be a power of two, at least 2");
   end

   logic [W-1:0] mem_q [DEPTH];
   logic [AW:0]  wr_q;
   logic [AW:0]  rd_q;

   wire full  = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
   wire empty = (wr_q == rd_q);
   wire push  = in_valid && !full;
   wire pop   = !empty && out_ready;

   assign in_ready  = !full;
   assign out_valid = !empty;
   assign out_data  = mem_q[rd_q[AW-1:0]];

   // Storage holds no reset; only the pointers define occupancy
   always_ff @(posedge clk) begin
      if (ce && push) begin
         mem_q[wr_q[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wr_q <= '0;
         rd_q <= '0;
      end else if (ce) begin
         if (flush) begin
            wr_q <= '0;
            rd_q <= '0;
         end else begin
            if (push)
               wr_q <= wr_q + 1'b1;
            if (pop)
               rd_q <= rd_q + 1'b1;
         end
      end
   end

endmodule // ldl_fifo

// >>> hdl/ldl_pkg.sv
// Constants, types and helpers for the loop converter serial latch.
// Assumes one 100 MHz system clock; host pins arrive asynchronously.
//
// Summary of operation
// - Each serial clock rising edge shifts the data input in, MSB first.
// - Load strobe rising edge queues the shift register word; the latch takes it at a later modulator step.
// - Serial clock edges between strobes are counted to classify the word.
// - Exactly 16 edges: normal word, 16 bits move to the latch.
// - Normal code is straight binary, zeros 4 mA up to ones 20 mA.
// - More than 16 edges: alarm word, 17 bits taken.
// - Beyond 17 edges only the last 17 bits are kept.
// - Alarm code is straight binary, zeros 0 mA up to ones 32 mA.
// - Reference overload: modulator off, oscillator stopped, latch cleared.
// - Second-order modulator turns the latched code into one bit stream.

package ldl_pkg;

   // ----------------------------------------------------------------
   // Word layout
   // ----------------------------------------------------------------
   localparam int NORM_BITS  = 16;
   localparam int ALARM_BITS = 17;
   localparam int WORD_W     = ALARM_BITS + 1;

   // ----------------------------------------------------------------
   // Edge counter
   // ----------------------------------------------------------------
   localparam logic [4:0] CNT_RST    = 5'h00;
   localparam logic [4:0] CNT_NORMAL = 5'h10;
   localparam logic [4:0] CNT_SAT    = 5'h12;

   // ----------------------------------------------------------------
   // Reset values and code scaling
   // ----------------------------------------------------------------
   localparam logic [16:0] CODE_RST    = 17'h00000;
   localparam logic [16:0] NORM_OFFSET = 17'h04000;
   localparam int          MOD_FS      = 1 << ALARM_BITS;
   // Pin sync reset levels match idle pins: strobe high, others low,
   // so no false strobe edge follows reset
   localparam logic [3:0]  PIN_RST     = 4'h4;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS      = 10;
   localparam int SCLK_MIN_PERIOD_NS = 100;
   localparam int SCLK_MIN_CYC       = SCLK_MIN_PERIOD_NS / CLK_PERIOD_NS;
   localparam int SYNC_STAGES        = 2;
   localparam int OSC_DIV_DEF        = 4;
   localparam int MOD_W_DEF          = 24;
   localparam int FIFO_DEPTH_DEF     = 2;

   typedef enum logic [1:0] {
      LDL_IGNORE,
      LDL_NORMAL,
      LDL_ALARM
   } ldl_kind_t;

   function automatic ldl_kind_t ldl_classify(input logic [4:0] cnt);
      if (cnt == CNT_NORMAL)
         return LDL_NORMAL;
      else if (cnt > CNT_NORMAL)
         return LDL_ALARM;
      else
         return LDL_IGNORE;
   endfunction

endpackage

// >>> hdl/ldl_top.sv
// Serial input, converter latch and bit-stream modulator.
// Assumes host pins and the reference overload sense are asynchronous.
`timescale 1ns/1ps

module ldl_top
   import ldl_pkg::*;
#(
   parameter int OSC_DIV    = OSC_DIV_DEF,
   parameter int MOD_W      = MOD_W_DEF,
   parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
   // Clocking
   input  wire logic        ref_clk,
   input  wire logic        resetn,
   input  wire logic        clk_en,
   // Host serial pins
   input  wire logic        ser_clk,
   input  wire logic        ser_data,
   input  wire logic        load_strobe,
   // Load sense on reference_output_b
   input  wire logic        ref_b_overload,
   // Converter state
   output logic [16:0]      code_q,
   output logic             alarm_q,
   output logic             dac_bit_q,
   output logic             mod_on_q,
   output logic             osc_on_q
);

   // ----------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------
   if (OSC_DIV < 2) begin : g_bad_div
      $error("OSC_DIV must be at least 2");
   end
   if (MOD_W < ALARM_BITS + 4) begin : g_bad_modw
      $error("MOD_W too narrow for modulator headroom");
   end
   // Edge detection must settle inside half the fastest host period
   if (SCLK_MIN_CYC / 2 < SYNC_STAGES + 1) begin : g_bad_rate
      $error("System clock too slow for host serial clock");
   end

   localparam int DW = (OSC_DIV > 2) ? $clog2(OSC_DIV) : 1;

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   localparam int NPIN = 4;
   localparam int P_CLK = 0;
   localparam int P_DAT = 1;
   localparam int P_STB = 2;
   localparam int P_OVL = 3;

   logic [NPIN-1:0] pin_a;
   logic [NPIN-1:0] pin_m_q;
   logic [NPIN-1:0] pin_s_q;
   logic [NPIN-1:0] pin_p_q;

   assign pin_a = {ref_b_overload, load_strobe, ser_data, ser_clk};

   for (genvar i = 0; i < NPIN; i++) begin : g_sync
      always_ff @(posedge ref_clk or negedge resetn) begin
         if (!resetn) begin
            pin_m_q[i] <= PIN_RST[i];
            pin_s_q[i] <= PIN_RST[i];
            pin_p_q[i] <= PIN_RST[i];
         end else if (clk_en) begin
            pin_m_q[i] <= pin_a[i];
            pin_s_q[i] <= pin_m_q[i];
            pin_p_q[i] <= pin_s_q[i];
         end
      end
   end

   wire clk_rise = pin_s_q[P_CLK] && !pin_p_q[P_CLK];
   wire stb_rise = pin_s_q[P_STB] && !pin_p_q[P_STB];
   wire dat_s    = pin_s_q[P_DAT];
   wire ovl_s    = pin_s_q[P_OVL];

   // ----------------------------------------------------------------
   // Shift register and edge counter
   // ----------------------------------------------------------------
   logic [16:0] sr_q;
   logic [16:0] sr_d;
   logic [4:0]  cnt_q;
   logic [4:0]  cnt_d;

   // Older bits fall off the top, so a long write keeps its last 17
   assign sr_d = clk_rise ? {sr_q[15:0], dat_s} : sr_q;

   // An edge in the strobe cycle belongs to the next word
   wire [4:0] cnt_inc  = (cnt_q == CNT_SAT) ? cnt_q : cnt_q + 5'h01;
   wire [4:0] cnt_next = clk_rise ? cnt_inc : cnt_q;
   wire [4:0] cnt_new  = clk_rise ? 5'h01 : CNT_RST;
   assign cnt_d = stb_rise ? cnt_new : cnt_next;

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         sr_q  <= CODE_RST;
         cnt_q <= CNT_RST;
      end else if (clk_en) begin
         sr_q  <= sr_d;
         cnt_q <= cnt_d;
      end
   end

   // ----------------------------------------------------------------
   // Word capture on strobe
   // ----------------------------------------------------------------
   ldl_kind_t kind;
   assign kind = ldl_classify(cnt_q);

   wire              is_alarm = (kind == LDL_ALARM);
   wire              take     = stb_rise && (kind != LDL_IGNORE) && !ovl_s;
   wire [16:0]       norm_cap = {1'b0, sr_q[NORM_BITS-1:0]};
   wire [16:0]       cap_code = is_alarm ? sr_q : norm_cap;
   wire [WORD_W-1:0] cap_word = {is_alarm, cap_code};

   logic              pend_q;
   logic [WORD_W-1:0] pend_word_q;
   logic              fifo_in_ready;
   logic              fifo_out_valid;
   logic [WORD_W-1:0] fifo_out_data;

   // A word waits here while the buffer is full; a newer strobe replaces it
   wire pend_push = pend_q && fifo_in_ready;
   wire pend_d    = !ovl_s && (take || (pend_q && !pend_push));

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         pend_q      <= 1'b0;
         pend_word_q <= '0;
      end else if (clk_en) begin
         pend_q <= pend_d;
         if (take)
            pend_word_q <= cap_word;
      end
   end

   // ----------------------------------------------------------------
   // Oscillator and latch
   // ----------------------------------------------------------------
   logic [DW-1:0] div_q;

   wire osc_tick = osc_on_q && (div_q == DW'(OSC_DIV - 1));
   wire mod_step = osc_tick && mod_on_q;
   wire pop      = mod_step && fifo_out_valid;

   ldl_fifo #(
      .W     (WORD_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk       (ref_clk),
      .rstn      (resetn),
      .ce        (clk_en),
      .flush     (ovl_s),
      .in_valid  (pend_q),
      .in_data   (pend_word_q),
      .in_ready  (fifo_in_ready),
      .out_valid (fifo_out_valid),
      .out_data  (fifo_out_data),
      .out_ready (mod_step)
   );

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         div_q    <= '0;
         osc_on_q <= 1'b0;
         mod_on_q <= 1'b0;
      end else if (clk_en) begin
         osc_on_q <= !ovl_s;
         mod_on_q <= !ovl_s;
         if (ovl_s || osc_tick)
            div_q <= '0;
         else if (osc_on_q)
            div_q <= div_q + 1'b1;
      end
   end

   // Latch loads only at a modulator step so a sample never tears
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         code_q  <= CODE_RST;
         alarm_q <= 1'b0;
      end else if (clk_en) begin
         if (ovl_s) begin
            code_q  <= CODE_RST;
            alarm_q <= 1'b0;
         end else if (pop) begin
            code_q  <= fifo_out_data[16:0];
            alarm_q <= fifo_out_data[WORD_W-1];
         end
      end
   end

   // ----------------------------------------------------------------
   // Second-order modulator
   // ----------------------------------------------------------------
   // Both modes share one 17-bit scale of equal step, 4 mA at 0x04000
   wire [16:0] norm_lvl = NORM_OFFSET + {1'b0, code_q[NORM_BITS-1:0]};
   wire [16:0] mod_in   = alarm_q ? code_q : norm_lvl;

   logic signed [MOD_W-1:0] int1_q;
   logic signed [MOD_W-1:0] int2_q;

   wire signed [MOD_W-1:0] x_s  = signed'(MOD_W'(mod_in));
   wire signed [MOD_W-1:0] fs_s = signed'(MOD_W'(MOD_FS));
   wire signed [MOD_W-1:0] fb_s = dac_bit_q ? fs_s : '0;
   wire signed [MOD_W-1:0] i1_d = int1_q + x_s - fb_s;
   wire signed [MOD_W-1:0] i2_d = int2_q + i1_d - fb_s;

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         int1_q    <= '0;
         int2_q    <= '0;
         dac_bit_q <= 1'b0;
      end else if (clk_en) begin
         if (!mod_on_q || ovl_s) begin
            int1_q    <= '0;
            int2_q    <= '0;
            dac_bit_q <= 1'b0;
         end else if (mod_step) begin
            int1_q    <= i1_d;
            int2_q    <= i2_d;
            dac_bit_q <= !i2_d[MOD_W-1];
         end
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk iff clk_en);
   endclocking
   default disable iff (!resetn);

   sequence s_strobe_normal;
      stb_rise && cnt_q == 5'h10 && !ovl_s;
   endsequence

   sequence s_strobe_alarm;
      stb_rise && cnt_q > 5'h10 && !ovl_s;
   endsequence

   a_shift_msb_in: assert property (
      clk_rise |=> sr_q == {$past(sr_q[15:0]), $past(dat_s)})
      else $error("shift register did not take the data bit");

   a_capture_normal: assert property (
      s_strobe_normal |=> pend_q && pend_word_q == {1'b0, 1'b0,
                                                   $past(sr_q[15:0])})
      else $error("normal word not captured as 16 bits");

   a_capture_alarm: assert property (
      s_strobe_alarm |=> pend_q && pend_word_q == {1'b1, $past(sr_q)})
      else $error("alarm word not captured as 17 bits");

   a_short_ignored: assert property (
      stb_rise && cnt_q < 5'h10 && !pend_q |=> !pend_q)
      else $error("short write was accepted");

   a_count_restart: assert property (
      stb_rise |=> cnt_q == (($past(clk_rise)) ? 5'h01 : 5'h00))
      else $error("edge counter did not restart at strobe");

   a_count_sat: assert property (
      cnt_q == 5'h12 && !stb_rise |=> cnt_q == 5'h12)
      else $error("edge counter left saturation");

   a_latch_load: assert property (
      pop && !ovl_s |=> code_q == $past(fifo_out_data[16:0])
                        && alarm_q == $past(fifo_out_data[WORD_W-1]))
      else $error("latch did not take the buffered word");

   a_overload_off: assert property (
      ovl_s |=> code_q == 17'h00000 && !osc_on_q && !mod_on_q
                ##1 !dac_bit_q)
      else $error("overload did not clear and stop the converter");

   a_level_scale: assert property (
      !alarm_q |-> mod_in == 17'(code_q[15:0] + 17'h04000))
      else $error("normal code not placed on the alarm scale");

   a_bit_idle: assert property (
      !mod_on_q [*2] |-> !dac_bit_q)
      else $error("bit stream active while modulator off");

   a_bit_rate: assert property (
      $changed(dac_bit_q) && mod_on_q |-> $past(mod_step))
      else $error("bit stream changed off the oscillator step");

   a_count_edge: assert property (
      clk_rise && !stb_rise && cnt_q < 5'h12 |=> cnt_q == $past(cnt_q) + 5'h01)
      else $error("edge counter missed a serial clock edge");

   a_normal_msb: assert property (
      !alarm_q |-> !code_q[16])
      else $error("normal code carries a seventeenth bit");

   a_osc_stopped: assert property (
      !osc_on_q |-> div_q == '0 && !mod_step)
      else $error("oscillator advanced while stopped");

   a_overload_drop: assert property (
      stb_rise && ovl_s |=> !pend_q)
      else $error("word taken during overload");

endmodule // ldl_top

// >>> testbench/ldl_host_model.sv
// Host serial port model driving clock, data and load strobe pins.
// Assumes one caller of send at a time; timing is its own, not ref_clk.
`timescale 1ns/1ps

module ldl_host_model (
   // Host serial pins
   output logic ser_clk,
   output logic ser_data,
   output logic load_strobe
);
   real half_ns = 62.5;

   initial begin
      ser_clk     = 1'b0;
      ser_data    = 1'b0;
      load_strobe = 1'b1;
   end

   // ----------------------------------------------------------------
   // Word transfer
   // ----------------------------------------------------------------
   // Clock idles low between frames; data flips once its hold is over,
   // so a stale bit never passes for a valid one
   task automatic send(input logic [23:0] w, input int n);
      load_strobe = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         ser_data = w[i];
         #(half_ns) ser_clk = 1'b1;
         #(half_ns) ser_clk = 1'b0;
      end
      ser_data = ~w[0];
      #(half_ns) load_strobe = 1'b1;
      #(half_ns);
   endtask
endmodule // ldl_host_model

// >>> testbench/testbench.sv
// Self-checking bench for the serial latch and bit-stream modulator.
// Assumes the host model times the serial pins on its own.
`timescale 1ns/1ps

module testbench;
   import ldl_pkg::*;

   typedef struct packed {
      logic [23:0] bits;
      int          n;
      logic [16:0] code;
      logic        alarm;
   } ldl_row_t;

   logic        ref_clk        = 1'b0;
   logic        resetn         = 1'b0;
   logic        clk_en         = 1'b1;
   logic        ref_b_overload = 1'b0;
   wire         ser_clk;
   wire         ser_data;
   wire         load_strobe;
   logic [16:0] code_q;
   logic        alarm_q;
   logic        dac_bit_q;
   logic        mod_on_q;
   logic        osc_on_q;
   int          bad_count = 0;
   int          cmp_count = 0;
   int          ones;
   logic [17:0] held;

   ldl_row_t rows [8] = '{
      '{24'h00ffff, 16, 17'h0ffff, 1'b0},
      '{24'h000000, 16, 17'h00000, 1'b0},
      '{24'h005a3c, 16, 17'h05a3c, 1'b0},
      '{24'h003c00, 17, 17'h03c00, 1'b1},
      '{24'hab4000, 24, 17'h14000, 1'b1},
      '{24'h023800, 18, 17'h03800, 1'b1},
      '{24'h018000, 17, 17'h18000, 1'b1},
      '{24'h008000, 16, 17'h08000, 1'b0}
   };

   always #5 ref_clk = ~ref_clk;

   ldl_top #(
      .OSC_DIV    (4),
      .MOD_W      (24),
      .FIFO_DEPTH (2)
   ) i_dut (
      .ref_clk        (ref_clk),
      .resetn         (resetn),
      .clk_en         (clk_en),
      .ser_clk        (ser_clk),
      .ser_data       (ser_data),
      .load_strobe    (load_strobe),
      .ref_b_overload (ref_b_overload),
      .code_q         (code_q),
      .alarm_q        (alarm_q),
      .dac_bit_q      (dac_bit_q),
      .mod_on_q       (mod_on_q),
      .osc_on_q       (osc_on_q)
   );

   ldl_host_model i_host (
      .ser_clk     (ser_clk),
      .ser_data    (ser_data),
      .load_strobe (load_strobe)
   );

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop;
      $display("compares=%0d mismatches=%0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   // Latency moves with modulator step and buffer fill, so poll
   task automatic wait_code(input logic [16:0] c, input logic a);
      for (int i = 0; i < 80 && !(code_q === c && alarm_q === a); i++)
         tick(1);
   endtask

   task automatic dens_check(input logic [16:0] lvl);
      int exp_ones;
      exp_ones = (4096 * lvl) >> 17;
      ones = 0;
      repeat (4096) begin
         tick(1);
         ones += (dac_bit_q === 1'b1);
      end
      check(ones > exp_ones - 64 && ones < exp_ones + 64, 1);
   endtask

   initial begin
      #500us;
      bad_count++;
      $display("watchdog expired");
      report_and_stop;
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      tick(12);
      resetn = 1'b1;
      tick(3);
      check({mod_on_q, osc_on_q}, 2'b11);
      foreach (rows[r]) begin
         i_host.send(rows[r].bits, rows[r].n);
         wait_code(rows[r].code, rows[r].alarm);
         check(code_q, rows[r].code);
         check(alarm_q, rows[r].alarm);
         $display("row %0d done", r);
      end
      // Short word is dropped and must not leak into the next count
      i_host.send(24'h007fff, 15);
      tick(80);
      check(code_q, 17'h08000);
      i_host.send(24'h001234, 16);
      wait_code(17'h01234, 1'b0);
      check({alarm_q, code_q}, 18'h01234);
      $display("short word done");
      // Words back to back through the buffer
      i_host.send(24'h00aaaa, 16);
      i_host.send(24'h005555, 16);
      i_host.send(24'h00c3c3, 16);
      wait_code(17'h0c3c3, 1'b0);
      check({alarm_q, code_q}, 18'h0c3c3);
      dens_check(NORM_OFFSET + 17'h0c3c3);
      $display("burst done");
      // Enable low must freeze latch and bit stream alike
      held   = {dac_bit_q, code_q};
      clk_en = 1'b0;
      tick(20);
      check({dac_bit_q, code_q}, held);
      clk_en = 1'b1;
      tick(2);
      $display("enable done");
      ref_b_overload = 1'b1;
      tick(8);
      check({code_q, alarm_q, mod_on_q, osc_on_q, dac_bit_q}, 0);
      i_host.send(24'h007777, 16);
      tick(40);
      check(code_q, 17'h00000);
      ref_b_overload = 1'b0;
      tick(4);
      check({mod_on_q, osc_on_q}, 2'b11);
      dens_check(NORM_OFFSET);
      $display("overload done");
      resetn = 1'b0;
      tick(2);
      check({code_q, alarm_q, mod_on_q, osc_on_q, dac_bit_q}, 0);
      resetn = 1'b1;
      tick(3);
      i_host.send(24'h004321, 16);
      wait_code(17'h04321, 1'b0);
      check({alarm_q, code_q}, 18'h04321);
      $display("reset done");
      report_and_stop;
   end
endmodule // testbench
